//--- logic/swire_pkg.sv
package swire_pkg;

  // Core clock is 10 MHz, so one microsecond is ten cycles.
  localparam int unsigned CYC_PER_US = 10;

  // Phase counters are wide enough for the longest reset figure.
  localparam int unsigned CNT_W = 14;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam cnt_t CNT_ONE = 14'h0001;

  // Times in microseconds, then derived cycle counts.
  localparam int unsigned RESET_LOW_US        = 480;
  localparam int unsigned RESET_HIGH_US       = 480;
  localparam int unsigned PRESENCE_WAIT_US    = 30;
  localparam int unsigned PRESENCE_LOW_US     = 120;
  localparam int unsigned PRESENCE_SAMPLE_US  = 70;
  localparam int unsigned SLOT_US             = 80;
  localparam int unsigned WRITE_ONE_LOW_US    = 5;
  localparam int unsigned WRITE_ZERO_LOW_US   = 70;
  localparam int unsigned READ_START_LOW_US   = 2;
  localparam int unsigned READ_SAMPLE_US      = 12;
  localparam int unsigned RECOVERY_US         = 5;
  localparam int unsigned SLAVE_SAMPLE_US     = 30;

  localparam int unsigned RESET_LOW_CYC       = RESET_LOW_US * CYC_PER_US;
  localparam int unsigned RESET_HIGH_CYC      = RESET_HIGH_US * CYC_PER_US;
  localparam int unsigned PRESENCE_WAIT_CYC   = PRESENCE_WAIT_US * CYC_PER_US;
  localparam int unsigned PRESENCE_LOW_CYC    = PRESENCE_LOW_US * CYC_PER_US;
  localparam int unsigned PRESENCE_SAMPLE_CYC =
    PRESENCE_SAMPLE_US * CYC_PER_US;
  localparam int unsigned SLOT_CYC            = SLOT_US * CYC_PER_US;
  localparam int unsigned WRITE_ONE_LOW_CYC   = WRITE_ONE_LOW_US * CYC_PER_US;
  localparam int unsigned WRITE_ZERO_LOW_CYC  = WRITE_ZERO_LOW_US * CYC_PER_US;
  localparam int unsigned READ_START_LOW_CYC  = READ_START_LOW_US * CYC_PER_US;
  localparam int unsigned READ_SAMPLE_CYC     = READ_SAMPLE_US * CYC_PER_US;
  localparam int unsigned RECOVERY_CYC        = RECOVERY_US * CYC_PER_US;
  localparam int unsigned SLAVE_SAMPLE_CYC    = SLAVE_SAMPLE_US * CYC_PER_US;

  // Master command kinds.
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2
  } cmd_t;

endpackage : swire_pkg

//--- logic/swire_if.sv
`timescale 1ns/1ps
// Shared open-drain line with a pull-up: any enabled low driver wins.
interface swire_if;
  logic mst_out;  // Master drive level, always low.
  logic mst_oe;   // Master pulls the line.
  logic slv_out;  // Slave drive level, always low.
  logic slv_oe;   // Slave pulls the line.
  logic line;     // Resolved line level.

  // Wired-AND resolution; a released line reads high.
  assign line = (mst_oe ? mst_out : 1'h1) & (slv_oe ? slv_out : 1'h1);

  modport master (output mst_out, output mst_oe, input line);
  modport slave  (output slv_out, output slv_oe, input line);
endinterface : swire_if

//--- logic/swire_slave.sv
`timescale 1ns/1ps
module swire_slave #(
  parameter int unsigned RESET_DETECT_CYC = swire_pkg::RESET_LOW_CYC
) (
  input  wire logic clock,    // Core clock, 10 MHz.
  input  wire logic resetn,   // Asynchronous reset, active low.
  swire_if.slave    bus,      // Open-drain line.
  input  wire logic rd_mode,  // Next slot is a read slot.
  input  wire logic rd_bit,   // Bit to send in a read slot.
  output logic      rx_valid, // Pulse: a written bit was captured.
  output logic      rx_bit,   // Captured written bit.
  output logic      tx_done,  // Pulse: a read slot has been served.
  output logic      pres_done // Pulse: presence pulse finished.
);

  // One-hot phases of the slave.
  typedef enum logic [5:0] {
    S_WAIT_RST = 6'h01,
    S_RST_LOW  = 6'h02,
    S_PRES_WT  = 6'h04,
    S_PRES_LOW = 6'h08,
    S_READY    = 6'h10,
    S_SLOT     = 6'h20
  } slv_fsm_t;

  // Whole slave state in one record.
  typedef struct packed {
    slv_fsm_t       fsm;       // Current phase.
    swire_pkg::cnt_t cnt;      // Time since phase or slot start.
    swire_pkg::cnt_t low_cnt;  // Length of the current low level.
    logic           line_d;    // Line level one cycle ago.
    logic           drive;     // Pulling the line low.
    logic           rd_slot;   // Current slot is a read.
    logic           rx_valid;  // Capture pulse.
    logic           rx_bit;    // Captured bit.
    logic           tx_done;   // Read served pulse.
    logic           pres_done; // Presence finished pulse.
  } slv_state_t;

  localparam slv_state_t SLV_RESET = '{fsm: S_WAIT_RST, line_d: 1'h1,
                                      default: '0};

  slv_state_t st_r;   // Registered state.
  slv_state_t st_nxt; // Next state.
  logic       fall;   // Falling edge seen on the line.
  logic       rise;   // Rising edge seen on the line.

  assign fall = st_r.line_d & ~bus.line;
  assign rise = ~st_r.line_d & bus.line;

  // Next-state logic; the line is taken as synchronous to the clock.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.line_d    = bus.line;
    st_nxt.rx_valid  = 1'h0;
    st_nxt.tx_done   = 1'h0;
    st_nxt.pres_done = 1'h0;
    st_nxt.cnt       = st_r.cnt + swire_pkg::CNT_ONE;
    // Low length saturates so a very long low still counts as reset.
    if (bus.line) begin
      st_nxt.low_cnt = '0;
    end else if (st_r.low_cnt != swire_pkg::cnt_t'(RESET_DETECT_CYC)) begin
      st_nxt.low_cnt = st_r.low_cnt + swire_pkg::CNT_ONE;
    end
    case (st_r.fsm)
      S_WAIT_RST: begin
        // Slots before the first reset are ignored.
        st_nxt.drive = 1'h0;
      end
      S_RST_LOW: begin
        // Wait for the master to release the reset pulse.
        st_nxt.cnt = '0;
        if (rise) begin
          st_nxt.fsm = S_PRES_WT;
        end
      end
      S_PRES_WT: begin
        // Quiet gap before presence, inside the 15 to 60 us window.
        if (st_r.cnt == swire_pkg::cnt_t'(
            swire_pkg::PRESENCE_WAIT_CYC - 1)) begin
          st_nxt.fsm   = S_PRES_LOW;
          st_nxt.cnt   = '0;
          st_nxt.drive = 1'h1;
        end
      end
      S_PRES_LOW: begin
        // Presence low of 120 us, inside the 60 to 240 us window.
        if (st_r.cnt == swire_pkg::cnt_t'(
            swire_pkg::PRESENCE_LOW_CYC - 1)) begin
          st_nxt.fsm       = S_READY;
          st_nxt.drive     = 1'h0;
          st_nxt.pres_done = 1'h1;
        end
      end
      S_READY: begin
        // Only the master's falling edge opens a slot.
        st_nxt.cnt = '0;
        if (fall) begin
          st_nxt.fsm     = S_SLOT;
          st_nxt.rd_slot = rd_mode;
          // A read zero is driven the cycle after the edge is seen.
          st_nxt.drive   = rd_mode & ~rd_bit;
        end
      end
      S_SLOT: begin
        // Shared 30 us point: write sample and read release.
        if (st_r.cnt == swire_pkg::cnt_t'(
            swire_pkg::SLAVE_SAMPLE_CYC - 1)) begin
          if (st_r.rd_slot) begin
            st_nxt.drive   = 1'h0;
            st_nxt.tx_done = 1'h1;
          end else begin
            st_nxt.rx_bit   = bus.line;
            st_nxt.rx_valid = 1'h1;
          end
        end
        // Slot ends once past the sample point and the line is high.
        if (st_r.cnt >= swire_pkg::cnt_t'(swire_pkg::SLAVE_SAMPLE_CYC) &&
            bus.line) begin
          st_nxt.fsm = S_READY;
        end
      end
      default: begin
        st_nxt.fsm   = S_WAIT_RST;
        st_nxt.drive = 1'h0;
      end
    endcase
    // A long low restarts the sequence from any phase.
    if (st_r.low_cnt == swire_pkg::cnt_t'(RESET_DETECT_CYC - 1) &&
        !bus.line) begin
      st_nxt.fsm   = S_RST_LOW;
      st_nxt.drive = 1'h0;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= SLV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.slv_out = 1'h0;
  assign bus.slv_oe  = st_r.drive;
  assign rx_valid    = st_r.rx_valid;
  assign rx_bit      = st_r.rx_bit;
  assign tx_done     = st_r.tx_done;
  assign pres_done   = st_r.pres_done;

endmodule : swire_slave

//--- logic/swire_master.sv
`timescale 1ns/1ps
module swire_master #(
  parameter int unsigned RESET_LOW_CYC  = swire_pkg::RESET_LOW_CYC,
  parameter int unsigned RESET_HIGH_CYC = swire_pkg::RESET_HIGH_CYC
) (
  input  wire logic            clock,     // Core clock, 10 MHz.
  input  wire logic            resetn,    // Asynchronous reset, active low.
  swire_if.master              bus,       // Open-drain line.
  input  wire logic            cmd_valid, // Command offered.
  output logic                 cmd_ready, // Command accepted when high.
  input  wire swire_pkg::cmd_t cmd_kind,  // Reset, write or read.
  input  wire logic            cmd_bit,   // Bit for a write command.
  output logic                 rsp_valid, // Pulse: command complete.
  output logic                 rsp_bit    // Presence, read or write bit.
);

  // One-hot phases of the master.
  typedef enum logic [5:0] {
    M_IDLE     = 6'h01,
    M_RST_LOW  = 6'h02,
    M_RST_HIGH = 6'h04,
    M_SLOT_LOW = 6'h08,
    M_SLOT_REL = 6'h10,
    M_RECOVER  = 6'h20
  } mst_fsm_t;

  // Whole master state in one record.
  typedef struct packed {
    mst_fsm_t        fsm;       // Current phase.
    swire_pkg::cnt_t cnt;       // Time since phase or slot start.
    swire_pkg::cnt_t low_last;  // Last cycle of the slot's low part.
    logic            is_read;   // Current slot is a read.
    logic            drive;     // Pulling the line low.
    logic            rsp_valid; // Completion pulse.
    logic            rsp_bit;   // Result bit.
  } mst_state_t;

  localparam mst_state_t MST_RESET = '{fsm: M_IDLE, default: '0};

  // Compare points, one cycle before each phase boundary.
  localparam swire_pkg::cnt_t RST_LOW_END =
    swire_pkg::cnt_t'(RESET_LOW_CYC - 1);
  localparam swire_pkg::cnt_t RST_HIGH_END =
    swire_pkg::cnt_t'(RESET_HIGH_CYC - 1);
  localparam swire_pkg::cnt_t PRES_SAMPLE =
    swire_pkg::cnt_t'(swire_pkg::PRESENCE_SAMPLE_CYC - 1);
  localparam swire_pkg::cnt_t SLOT_END =
    swire_pkg::cnt_t'(swire_pkg::SLOT_CYC - 1);
  localparam swire_pkg::cnt_t READ_SAMPLE =
    swire_pkg::cnt_t'(swire_pkg::READ_SAMPLE_CYC - 1);
  localparam swire_pkg::cnt_t REC_END =
    swire_pkg::cnt_t'(swire_pkg::RECOVERY_CYC - 1);
  localparam swire_pkg::cnt_t W1_LAST =
    swire_pkg::cnt_t'(swire_pkg::WRITE_ONE_LOW_CYC - 1);
  localparam swire_pkg::cnt_t W0_LAST =
    swire_pkg::cnt_t'(swire_pkg::WRITE_ZERO_LOW_CYC - 1);
  localparam swire_pkg::cnt_t RD_LAST =
    swire_pkg::cnt_t'(swire_pkg::READ_START_LOW_CYC - 1);

  // Timing at the 10 MHz core clock. A write-one low lasts 50 cycles and
  // a write-zero low 700, so a slave that samples near 300 cycles tells
  // them apart with a wide margin on both sides. The read start low of
  // 20 cycles ends long before the read sample at 120 cycles, which
  // leaves the slave the whole gap to settle its level. Slot and
  // recovery add up to 850 cycles from take to answer for every slot.
  // The trade-off is throughput: the slot sits mid-window rather than
  // at its shortest, in exchange for tolerance on both ends.
  mst_state_t st_r;   // Registered state.
  mst_state_t st_nxt; // Next state.

  // Next-state logic. Both slot phases run on one counter that starts at
  // zero in the first cycle the line is low, so slot times are measured
  // from the master's own falling edge.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rsp_valid = 1'h0;
    st_nxt.cnt       = st_r.cnt + swire_pkg::CNT_ONE;
    case (st_r.fsm)
      M_IDLE: begin
        // The line stays released while no command is pending.
        st_nxt.cnt   = '0;
        st_nxt.drive = 1'h0;
        if (cmd_valid) begin
          case (cmd_kind)
            swire_pkg::CMD_RESET: begin
              // A reset may follow any slot; the slave abandons whatever
              // it was doing once the low has lasted long enough.
              st_nxt.fsm   = M_RST_LOW;
              st_nxt.drive = 1'h1;
            end
            swire_pkg::CMD_WRITE: begin
              st_nxt.fsm      = M_SLOT_LOW;
              st_nxt.drive    = 1'h1;
              st_nxt.is_read  = 1'h0;
              st_nxt.rsp_bit  = cmd_bit;
              // Short low writes a one, long low writes a zero.
              st_nxt.low_last = cmd_bit ? W1_LAST : W0_LAST;
            end
            swire_pkg::CMD_READ: begin
              st_nxt.fsm      = M_SLOT_LOW;
              st_nxt.drive    = 1'h1;
              st_nxt.is_read  = 1'h1;
              st_nxt.low_last = RD_LAST;
            end
            default: begin
              // Unknown kinds are consumed and answered at once.
              st_nxt.rsp_valid = 1'h1;
              st_nxt.rsp_bit   = 1'h0;
            end
          endcase
        end
      end
      M_RST_LOW: begin
        // Reset low lasts exactly 480 us, well inside the 960 us limit.
        if (st_r.cnt == RST_LOW_END) begin
          st_nxt.fsm   = M_RST_HIGH;
          st_nxt.drive = 1'h0;
          st_nxt.cnt   = '0;
        end
      end
      M_RST_HIGH: begin
        // Presence is looked for after the longest wait has passed, and
        // before the shortest presence low can have ended.
        // A missing slave leaves the line high and answers zero.
        if (st_r.cnt == PRES_SAMPLE) begin
          st_nxt.rsp_bit = ~bus.line;
        end
        // The line stays released for the full high time.
        if (st_r.cnt == RST_HIGH_END) begin
          st_nxt.fsm       = M_IDLE;
          st_nxt.rsp_valid = 1'h1;
        end
      end
      M_SLOT_LOW: begin
        // Release after the low part chosen for this slot.
        // The slave sees the falling edge in the same cycle and times from the next one.
        if (st_r.cnt == st_r.low_last) begin
          st_nxt.fsm   = M_SLOT_REL;
          st_nxt.drive = 1'h0;
        end
      end
      M_SLOT_REL: begin
        // Read bit is sampled at 12 us, inside the valid window.
        // Sampling late in the window gives a slow pull-up time to lift
        // the line, while still ahead of the slave's release.
        if (st_r.is_read && st_r.cnt == READ_SAMPLE) begin
          st_nxt.rsp_bit = bus.line;
        end
        // Slot length of 80 us sits inside the 60 to 120 us window.
        if (st_r.cnt == SLOT_END) begin
          st_nxt.fsm = M_RECOVER;
          st_nxt.cnt = '0;
        end
      end
      M_RECOVER: begin
        // Line held high before the next command may start a slot.
        // The answer pulses here, so the result bit is already settled.
        if (st_r.cnt == REC_END) begin
          st_nxt.fsm       = M_IDLE;
          st_nxt.rsp_valid = 1'h1;
        end
      end
      default: begin
        // An illegal code falls back to idle with the line released.
        st_nxt.fsm   = M_IDLE;
        st_nxt.drive = 1'h0;
      end
    endcase
  end

  // State register. Reset leaves the line released and the master idle,
  // so a command offered straight after reset is taken at once.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= MST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The master only ever pulls low; the pull-up makes the high level.
  assign bus.mst_out = 1'h0;
  assign bus.mst_oe  = st_r.drive;

  // Commands are taken only while idle, so a slot never overlaps another.
  // The ready flag is combinational from the phase register, so an offer
  // made in the cycle the answer pulses is taken at the next edge.
  assign cmd_ready = (st_r.fsm == M_IDLE);
  assign rsp_valid = st_r.rsp_valid;
  assign rsp_bit   = st_r.rsp_bit;

endmodule : swire_master

//--- bench/swire_chk.sv
`timescale 1ns/1ps
// Watches one shared line with both pull-down enables and times every low.
module swire_chk (
  input wire logic clock,   // Core clock.
  input wire logic resetn,  // Asynchronous reset, active low.
  input wire logic mst_out, // Master drive level.
  input wire logic mst_oe,  // Master pulls the line.
  input wire logic slv_out, // Slave drive level.
  input wire logic slv_oe,  // Slave pulls the line.
  input wire logic line     // Resolved line level.
);
  localparam logic [13:0] SAT = 14'h3FFF; // Counter ceiling.
  logic [13:0] mst_cnt_r;  // Cycles the master has held low.
  logic [13:0] slv_cnt_r;  // Cycles the slave has held low.
  logic [13:0] high_cnt_r; // Cycles the line has stayed high.
  logic [13:0] gap_cnt_r;  // Cycles since the master last began a low.
  logic        slv_q_r;    // Slave enable one cycle ago.
  logic        pres_r;     // Current slave low began with the master off.

  // Idle counters start saturated, so the first slot after reset is not
  // taken for one that follows another too closely.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mst_cnt_r  <= 14'h0000;
      slv_cnt_r  <= 14'h0000;
      high_cnt_r <= SAT;
      gap_cnt_r  <= SAT;
      slv_q_r    <= 1'h0;
      pres_r     <= 1'h0;
    end else begin
      mst_cnt_r  <= mst_oe ? mst_cnt_r + 14'h0001 : 14'h0000;
      slv_cnt_r  <= slv_oe ? slv_cnt_r + 14'h0001 : 14'h0000;
      high_cnt_r <= !line ? 14'h0000 :
                    (high_cnt_r == SAT ? SAT : high_cnt_r + 14'h0001);
      gap_cnt_r  <= (mst_oe && mst_cnt_r == 14'h0000) ? 14'h0001 :
                    (gap_cnt_r == SAT ? SAT : gap_cnt_r + 14'h0001);
      slv_q_r    <= slv_oe;
      if (slv_oe && !slv_q_r) begin
        pres_r <= !mst_oe;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  pres_wait_a : assert property (
    $rose(slv_oe) && !mst_oe |-> high_cnt_r inside {[150:600]})
    else $error("presence began outside its wait");
  pres_low_a : assert property (
    $fell(slv_oe) && pres_r |-> slv_cnt_r inside {[600:2400]})
    else $error("presence low of wrong length");
  read_valid_a : assert property (
    $rose(slv_oe) && mst_oe |-> mst_cnt_r inside {[1:10]})
    else $error("read zero driven late");
  read_release_a : assert property (
    $fell(slv_oe) && !pres_r |-> slv_cnt_r inside {[148:598]})
    else $error("read zero released out of window");
  slave_start_a : assert property (
    $rose(slv_oe) |-> mst_oe || high_cnt_r >= 150)
    else $error("slave pulled an idle line");
  drive_low_a : assert property (
    (mst_oe |-> !mst_out) and (slv_oe |-> !slv_out))
    else $error("enabled driver not low");
  short_low_a : assert property (
    $fell(mst_oe) && mst_cnt_r < 300 |-> mst_cnt_r inside {[10:150]})
    else $error("short master low of wrong length");
  long_low_a : assert property (
    $fell(mst_oe) && mst_cnt_r >= 300 |-> mst_cnt_r inside {[600:9599]})
    else $error("long master low of wrong length");
  recovery_a : assert property (
    $rose(mst_oe) |-> high_cnt_r >= 10)
    else $error("recovery too short");
  slot_len_a : assert property (
    $rose(mst_oe) |-> gap_cnt_r >= 610)
    else $error("slot too short");

  cover property ($fell(slv_oe) && pres_r);
  cover property ($fell(slv_oe) && !pres_r);
  cover property ($fell(mst_oe) && mst_cnt_r inside {[600:800]});
endmodule : swire_chk

//--- bench/single_wire_slave_signaling_tb_top.sv
`timescale 1ns/1ps
// Joins a master and a slave on one line and runs resets, writes, reads.
module single_wire_slave_signaling_tb_top;
  logic            clock;     // Core clock.
  logic            resetn;    // Reset, active low.
  logic            cmd_valid; // Command offered.
  logic            cmd_ready; // Master idle.
  logic            cmd_bit;   // Bit to write.
  logic            rsp_valid; // Command complete.
  logic            rsp_bit;   // Answer bit.
  logic            rd_mode;   // Slave sends in the next slot.
  logic            rd_bit;    // Bit the slave sends.
  logic            rx_valid;  // Slave captured a bit.
  logic            rx_bit;    // Captured bit.
  logic            tx_done;   // Slave served a read.
  logic            pres_done; // Slave finished presence.
  logic            got;       // Last answer bit.
  swire_pkg::cmd_t cmd_kind;  // Command kind.
  int              n_errors;  // Mismatches.
  int              checks;    // Comparisons.
  int              n_rx;      // Captures seen.
  int              n_tx;      // Reads served.
  int              n_pres;    // Presences seen.
  int              cyc;       // Cycles from take to answer.

  swire_if swire_if_inst ();

  // Short reset figures keep the run brief. The slave's detect threshold
  // must stay above its own presence low of 1200 cycles and the master's
  // write-zero low of 700, and below the master's reset low.
  localparam int TB_RST_LOW  = 1400;  // Master reset low, cycles.
  localparam int TB_RST_HIGH = 2000;  // Master release after reset.
  localparam int TB_DETECT   = 1300;  // Slave reset detect threshold.
  localparam int CMD_LIMIT   = 20000; // Cycle limit for one command.

  swire_master #(.RESET_LOW_CYC(TB_RST_LOW), .RESET_HIGH_CYC(TB_RST_HIGH))
    swire_master_inst (.clock(clock), .resetn(resetn),
    .bus(swire_if_inst.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_bit(cmd_bit),
    .rsp_valid(rsp_valid), .rsp_bit(rsp_bit));
  swire_slave #(.RESET_DETECT_CYC(TB_DETECT)) swire_slave_inst (.clock(clock),
    .resetn(resetn), .bus(swire_if_inst.slave), .rd_mode(rd_mode),
    .rd_bit(rd_bit), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .tx_done(tx_done), .pres_done(pres_done));
  swire_chk swire_chk_inst (.clock(clock), .resetn(resetn),
    .mst_out(swire_if_inst.mst_out), .mst_oe(swire_if_inst.mst_oe),
    .slv_out(swire_if_inst.slv_out), .slv_oe(swire_if_inst.slv_oe),
    .line(swire_if_inst.line));

  // Free-running clock, 100 ns period.
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // Slave pulses are counted mid-cycle, where they have settled.
  always @(negedge clock) begin
    if (rx_valid === 1'h1) n_rx++;
    if (tx_done === 1'h1) n_tx++;
    if (pres_done === 1'h1) n_pres++;
  end

  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t saw %b expected %b", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Called at a falling edge with the master idle; the offer is taken at
  // the next rising edge, so it is withdrawn one falling edge later.
  task automatic cmd(input swire_pkg::cmd_t k, input logic b);
    cmd_valid = 1'h1;
    cmd_kind  = k;
    cmd_bit   = b;
    check(cmd_ready, 1'h1);
    @(negedge clock);
    cmd_valid = 1'h0;
    // Only the spare kind leaves the master idle once it is taken.
    check(cmd_ready, k == swire_pkg::cmd_t'(2'h3));
    cyc = 1;
    while (rsp_valid !== 1'h1 && cyc < CMD_LIMIT) begin
      @(negedge clock);
      cyc++;
    end
    // A command that never answers counts as a mismatch.
    check(cyc < CMD_LIMIT, 1'h1);
    got = rsp_bit;
  endtask : cmd

  // Before any reset the slave must leave a read slot alone.
  task automatic t_unreset();
    rd_mode = 1'h1;
    rd_bit  = 1'h0;
    cmd(swire_pkg::CMD_READ, 1'h0);
    check(got, 1'h1);
    check(n_tx == 0, 1'h1);
  endtask : t_unreset

  task automatic t_reset();
    int p;
    p = n_pres;
    cmd(swire_pkg::CMD_RESET, 1'h0);
    check(got, 1'h1);
    check(n_pres == p + 1, 1'h1);
    check(cyc >= TB_RST_LOW + TB_RST_HIGH, 1'h1);
  endtask : t_reset

  // Writes of both values, back to back.
  task automatic t_write();
    int r;
    rd_mode = 1'h0;
    for (int b = 0; b < 2; b++) begin
      r = n_rx;
      cmd(swire_pkg::CMD_WRITE, b[0]);
      check(rx_bit, b[0]);
      check(n_rx == r + 1, 1'h1);
      check(got, b[0]);
      check(cyc >= 600 && cyc <= 1200, 1'h1);
    end
  endtask : t_write

  // Reads of both values, run after the writes and again after the second reset.
  task automatic t_read();
    int t;
    rd_mode = 1'h1;
    for (int b = 0; b < 2; b++) begin
      rd_bit = b[0];
      t = n_tx;
      cmd(swire_pkg::CMD_READ, 1'h0);
      check(got, b[0]);
      check(n_tx == t + 1, 1'h1);
    end
  endtask : t_read

  // The unused kind completes at once and answers zero.
  task automatic t_spare();
    cmd(swire_pkg::cmd_t'(2'h3), 1'h1);
    check(got, 1'h0);
    check(cyc <= 2, 1'h1);
  endtask : t_spare

  initial begin
    resetn    = 1'h0;
    cmd_valid = 1'h0;
    cmd_kind  = swire_pkg::CMD_RESET;
    cmd_bit   = 1'h0;
    rd_mode   = 1'h0;
    rd_bit    = 1'h0;
    repeat (4) @(negedge clock);
    resetn = 1'h1;
    @(negedge clock);
    t_unreset();
    t_reset();
    t_write();
    t_read();
    t_spare();
    // A second reset after traffic must bring presence again.
    t_reset();
    t_read();
    report_and_stop();
  end

  // Cuts a hang short; the tests need under 20000 cycles.
  initial begin
    #(40000 * 100);
    n_errors++;
    report_and_stop();
  end
endmodule : single_wire_slave_signaling_tb_top
